// *** rtl/aoc_pkg.sv ***
// shared constants and types of the accessory output controller
package aoc_pkg;
	// register byte offsets
	localparam logic [7:0] AOC_OFF_CMD = 8'h00;
	localparam logic [7:0] AOC_OFF_PAIR_CFG = 8'h04;
	localparam logic [7:0] AOC_OFF_ONTIME = 8'h08;
	localparam logic [7:0] AOC_OFF_SERVO_CFG = 8'h0C;
	localparam logic [7:0] AOC_OFF_SERVO_POS = 8'h10;
	localparam logic [7:0] AOC_OFF_STATUS = 8'h14;
	localparam logic [7:0] AOC_OFF_SELECT = 8'h18;
	// command register fields: bits 7:0 hold one request bit per output (pair*2+side)
	localparam int AOC_NOUT = 8;
	localparam int AOC_NPAIR = 4;
	// pair config: 2 bits per pair, bit 8 enables fading
	localparam logic [1:0] AOC_MODE_LATCH = 2'h0;
	localparam logic [1:0] AOC_MODE_PULSE = 2'h1;
	localparam logic [1:0] AOC_MODE_BLINK = 2'h2;
	localparam int AOC_FADE_BIT = 8;
	// on-time register: 8-bit count in 10 ms units; zero makes pulsed pairs follow the command
	localparam int AOC_ONTIME_W = 8;
	localparam logic [7:0] AOC_ONTIME_RST = 8'h0A;
	localparam int AOC_CLK_HZ = 20000000;
	localparam int AOC_TICK_MS = 10;
	localparam int AOC_TICK_CYC = AOC_CLK_HZ / 1000 * AOC_TICK_MS;
	// servo frame and pulse figures
	localparam int AOC_FRAME_US = 20000;
	localparam int AOC_PMIN_US = 1000;
	localparam int AOC_PMAX_US = 2000;
	localparam int AOC_FRAME_CYC = AOC_CLK_HZ / 1000000 * AOC_FRAME_US;
	localparam int AOC_PMIN_CYC = AOC_CLK_HZ / 1000000 * AOC_PMIN_US;
	localparam int AOC_PSTEP_CYC = (AOC_CLK_HZ / 1000000 * (AOC_PMAX_US - AOC_PMIN_US)) / 255;
	// servo cfg per servo (byte each): [0] gate pulses at end, [1] power off,
	// [2] power cut at end, [7:4] speed (position steps per frame)
	localparam int AOC_SV_GATE = 0;
	localparam int AOC_SV_PWROFF = 1;
	localparam int AOC_SV_CUT = 2;
	// fade ramp: 8-bit pwm level, stepped every fade tick
	localparam int AOC_FADE_CYC = 2000;
	// mode selector codes
	typedef enum logic [1:0] {
		AOC_SEL_USER = 2'h0,
		AOC_SEL_PULSE = 2'h1,
		AOC_SEL_LATCH = 2'h2
	} aoc_sel_t;
endpackage : aoc_pkg

// *** rtl/aoc_servo.sv ***
// one servo channel: speed-limited travel and 1-2 ms pulse in a 20 ms frame
`timescale 1ns/1ps
module aoc_servo import aoc_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// frame start strobe shared by all channels
	input wire logic frame_start,
	input wire logic [31:0] frame_cnt,
	// configuration
	input wire logic [7:0] target,
	input wire logic [3:0] speed,
	input wire logic gate_at_end,
	input wire logic pwr_off,
	input wire logic cut_at_end,
	// outputs
	output logic pulse_q,
	output logic power_q,
	output logic [7:0] pos_q
);
	logic pulse_d;
	logic power_d;
	logic [7:0] pos_d;
	logic at_end;
	logic [31:0] width;

	always_comb begin
		pos_d = pos_q;
		if (frame_start) begin
			// travel speed: speed 0 jumps at once
			if (speed == 4'h0) begin
				pos_d = target;
			end else if (target > pos_q) begin
				pos_d = (target - pos_q > {4'h0, speed}) ? pos_q + {4'h0, speed} : target;
			end else if (target < pos_q) begin
				pos_d = (pos_q - target > {4'h0, speed}) ? pos_q - {4'h0, speed} : target;
			end
		end
		at_end = (pos_q == target);
		width = 32'(AOC_PMIN_CYC) + 32'(pos_q) * 32'(AOC_PSTEP_CYC);
		// pulse width proportional to position, gated once the lever rests
		pulse_d = (frame_cnt < width) && !(gate_at_end && at_end);
		// supply switched off on demand or at end position
		power_d = !pwr_off && !(cut_at_end && at_end);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pulse_q <= 1'b0;
			power_q <= 1'b0;
			pos_q <= 8'h80;
		end else begin
			pulse_q <= pulse_d;
			power_q <= power_d;
			pos_q <= pos_d;
		end
	end

	property p_pulse_max;
		@(posedge hclk) disable iff (!hresetn)
		pulse_q |-> frame_cnt <= 32'(AOC_PMIN_CYC + AOC_PSTEP_CYC * 255 + 1);
	endproperty
	a_pulse_max: assert property (p_pulse_max) else $error("servo pulse longer than 2 ms");
endmodule : aoc_servo

// *** rtl/aoc_top.sv ***
// accessory output controller: four output pairs, two servos, ahb-lite registers
// Behaviour
// - four output pairs plus two servo outputs
// - pair mode latched, pulsed or blinking
// - pulse selector forces pulsed drive
// - latch selector forces latched drive
// - centre selector uses stored pair mode
// - selector never touches servo outputs
// - pulse starts with command, timer loaded
// - pulse lasts on-time minus up to one tick; a partner rise ends it
// - pulse ends at expiry despite command
// - zero on-time follows the command
// - latched output holds until partner commanded
// - latched pair never both on; with fading, both outputs pulse together during a change-over ramp
// - optional fading ramps lamp outputs
// - servo speed and end positions configurable
// - optional pulse stop at end position
// - per-servo supply switch-off control
// - blink alternates with on-time phases
// - servo pulse 1-2 ms every 20 ms
//
// Chosen here: the address map and register access over AHB-Lite.
`timescale 1ns/1ps
module aoc_top import aoc_pkg::*; (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [7:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// mode selector
	input wire logic forced_pulse_mode,
	input wire logic forced_latch_mode,
	// outputs
	output logic [7:0] out_q,
	output logic [1:0] servo_pulse_q,
	output logic [1:0] servo_power_q
);
	// bus state
	logic wr_pend_q, wr_pend_d;
	logic [7:0] addr_q, addr_d;
	logic [31:0] rdata_q, rdata_d;
	// registers
	logic [7:0] cmd_q, cmd_d;
	logic [8:0] pcfg_q, pcfg_d;
	logic [7:0] ontime_q, ontime_d;
	logic [15:0] scfg_q, scfg_d;
	logic [15:0] spos_q, spos_d;
	// output engine state
	logic [7:0] on_q, on_d;
	logic [7:0] cmd_prev_q, cmd_prev_d;
	logic [7:0] tmr_q [AOC_NPAIR];
	logic [7:0] tmr_d [AOC_NPAIR];
	logic [3:0] blink_ph_q, blink_ph_d;
	logic [31:0] tick_q, tick_d;
	logic [31:0] fdiv_q, fdiv_d;
	logic [7:0] lvl_q [AOC_NOUT];
	logic [7:0] lvl_d [AOC_NOUT];
	logic [7:0] pwm_q, pwm_d;
	logic [7:0] out_d;
	logic [31:0] frame_q, frame_d;
	logic [1:0] mode [AOC_NPAIR];
	logic [7:0] rise;
	logic tick;
	logic ftick;
	logic [15:0] spos_now;
	aoc_sel_t sel;

	assign hresp = 1'b0;
	assign hreadyout = 1'b1;
	assign hrdata = rdata_q;

	always_comb begin
		wr_pend_d = 1'b0;
		addr_d = addr_q;
		rdata_d = rdata_q;
		cmd_d = cmd_q;
		pcfg_d = pcfg_q;
		ontime_d = ontime_q;
		scfg_d = scfg_q;
		spos_d = spos_q;
		if (wr_pend_q) begin
			case (addr_q)
				AOC_OFF_CMD: cmd_d = hwdata[7:0];
				AOC_OFF_PAIR_CFG: pcfg_d = hwdata[8:0];
				AOC_OFF_ONTIME: ontime_d = hwdata[7:0];
				AOC_OFF_SERVO_CFG: scfg_d = hwdata[15:0];
				AOC_OFF_SERVO_POS: spos_d = hwdata[15:0];
				default: ;
			endcase
		end
		if (hsel && hready && htrans[1]) begin
			addr_d = {haddr[7:2], 2'b00};
			wr_pend_d = hwrite;
			if (!hwrite) begin
				case ({haddr[7:2], 2'b00})
					AOC_OFF_CMD: rdata_d = {24'h0, cmd_q};
					AOC_OFF_PAIR_CFG: rdata_d = {23'h0, pcfg_q};
					AOC_OFF_ONTIME: rdata_d = {24'h0, ontime_q};
					AOC_OFF_SERVO_CFG: rdata_d = {16'h0, scfg_q};
					AOC_OFF_SERVO_POS: rdata_d = {16'h0, spos_q};
					AOC_OFF_STATUS: rdata_d = {8'h0, spos_now, on_q};
					AOC_OFF_SELECT: rdata_d = {30'h0, sel};
					default: rdata_d = 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			addr_q <= 8'h00;
			rdata_q <= 32'h0;
			cmd_q <= 8'h00;
			pcfg_q <= 9'h000;
			ontime_q <= AOC_ONTIME_RST;
			scfg_q <= 16'h0000;
			spos_q <= 16'h8080;
		end else begin
			wr_pend_q <= wr_pend_d;
			addr_q <= addr_d;
			rdata_q <= rdata_d;
			cmd_q <= cmd_d;
			pcfg_q <= pcfg_d;
			ontime_q <= ontime_d;
			scfg_q <= scfg_d;
			spos_q <= spos_d;
		end
	end

	// selector resolution; both forcing pins high counts as pulse
	always_comb begin
		if (forced_pulse_mode) begin
			sel = AOC_SEL_PULSE;
		end else if (forced_latch_mode) begin
			sel = AOC_SEL_LATCH;
		end else begin
			sel = AOC_SEL_USER;
		end
		for (int p = 0; p < AOC_NPAIR; p++) begin
			case (sel)
				AOC_SEL_PULSE: mode[p] = AOC_MODE_PULSE;
				AOC_SEL_LATCH: mode[p] = AOC_MODE_LATCH;
				default: mode[p] = pcfg_q[2*p +: 2];
			endcase
		end
	end

	assign tick = (tick_q == 32'(AOC_TICK_CYC - 1));
	assign ftick = (fdiv_q == 32'(AOC_FADE_CYC - 1));
	assign rise = cmd_q & ~cmd_prev_q;

	always_comb begin
		on_d = on_q;
		blink_ph_d = blink_ph_q;
		cmd_prev_d = cmd_q;
		tick_d = tick ? 32'h0 : tick_q + 32'h1;
		fdiv_d = ftick ? 32'h0 : fdiv_q + 32'h1;
		pwm_d = pwm_q + 8'h01;
		for (int p = 0; p < AOC_NPAIR; p++) begin
			tmr_d[p] = tmr_q[p];
			case (mode[p])
				AOC_MODE_PULSE: begin
					if (ontime_q == 8'h00) begin
						on_d[2*p +: 2] = cmd_q[2*p +: 2];
					end else if (rise[2*p +: 2] != 2'b00) begin
						on_d[2*p +: 2] = rise[2*p +: 2];
						tmr_d[p] = ontime_q;
					end else if (tick && tmr_q[p] != 8'h00) begin
						tmr_d[p] = tmr_q[p] - 8'h01;
						if (tmr_q[p] == 8'h01) begin
							on_d[2*p +: 2] = 2'b00;
						end
					end
				end
				AOC_MODE_BLINK: begin
					if (tick) begin
						if (tmr_q[p] <= 8'h01) begin
							tmr_d[p] = ontime_q;
							blink_ph_d[p] = ~blink_ph_q[p];
						end else begin
							tmr_d[p] = tmr_q[p] - 8'h01;
						end
					end
					on_d[2*p +: 2] = blink_ph_q[p] ? 2'b10 : 2'b01;
				end
				default: begin
					if (rise[2*p]) begin
						on_d[2*p +: 2] = 2'b01;
					end else if (rise[2*p+1]) begin
						on_d[2*p +: 2] = 2'b10;
					end else if (on_q[2*p +: 2] == 2'b11) begin
						on_d[2*p +: 2] = 2'b00;
					end
				end
			endcase
		end
		for (int i = 0; i < AOC_NOUT; i++) begin
			lvl_d[i] = lvl_q[i];
			if (!pcfg_q[AOC_FADE_BIT]) begin
				lvl_d[i] = on_q[i] ? 8'hFF : 8'h00;
			end else if (ftick && on_q[i] && lvl_q[i] != 8'hFF) begin
				lvl_d[i] = lvl_q[i] + 8'h01;
			end else if (ftick && !on_q[i] && lvl_q[i] != 8'h00) begin
				lvl_d[i] = lvl_q[i] - 8'h01;
			end
			out_d[i] = pcfg_q[AOC_FADE_BIT] ? (pwm_q < lvl_q[i]) : on_q[i];
		end
		frame_d = (frame_q == 32'(AOC_FRAME_CYC - 1)) ? 32'h0 : frame_q + 32'h1;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			on_q <= 8'h00;
			cmd_prev_q <= 8'h00;
			blink_ph_q <= 4'h0;
			tick_q <= 32'h0;
			fdiv_q <= 32'h0;
			pwm_q <= 8'h00;
			out_q <= 8'h00;
			frame_q <= 32'h0;
			for (int p = 0; p < AOC_NPAIR; p++) begin
				tmr_q[p] <= 8'h00;
			end
			for (int i = 0; i < AOC_NOUT; i++) begin
				lvl_q[i] <= 8'h00;
			end
		end else begin
			on_q <= on_d;
			cmd_prev_q <= cmd_prev_d;
			blink_ph_q <= blink_ph_d;
			tick_q <= tick_d;
			fdiv_q <= fdiv_d;
			pwm_q <= pwm_d;
			out_q <= out_d;
			frame_q <= frame_d;
			tmr_q <= tmr_d;
			lvl_q <= lvl_d;
		end
	end

	for (genvar s = 0; s < 2; s++) begin : g_servo
		aoc_servo u_servo (
			.hclk(hclk),
			.hresetn(hresetn),
			.frame_start(frame_q == 32'h0),
			.frame_cnt(frame_q),
			.target(spos_q[8*s +: 8]),
			.speed(scfg_q[8*s+4 +: 4]),
			.gate_at_end(scfg_q[8*s+AOC_SV_GATE]),
			.pwr_off(scfg_q[8*s+AOC_SV_PWROFF]),
			.cut_at_end(scfg_q[8*s+AOC_SV_CUT]),
			.pulse_q(servo_pulse_q[s]),
			.power_q(servo_power_q[s]),
			.pos_q(spos_now[8*s +: 8])
		);
	end

	property p_latch_excl;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_LATCH |=> on_q[1:0] != 2'b11 && on_q[7:6] != 2'b11;
	endproperty
	a_latch_excl: assert property (p_latch_excl) else $error("both latched outputs on");

	property p_latch_set;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_LATCH && rise[0] |=> on_q[1:0] == 2'b01;
	endproperty
	a_latch_set: assert property (p_latch_set) else $error("latched A not set");

	property p_latch_hold;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_LATCH && $past(sel) == AOC_SEL_LATCH && rise[1:0] == 2'b00
		|=> on_q[1:0] == $past(on_q[1:0]);
	endproperty
	a_latch_hold: assert property (p_latch_hold) else $error("latched pair changed");

	property p_pulse_start;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_PULSE && ontime_q != 8'h00 && rise[2]
		|=> on_q[2] && tmr_q[1] == $past(ontime_q);
	endproperty
	a_pulse_start: assert property (p_pulse_start) else $error("pulse did not start");

	property p_pulse_min;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_PULSE && ontime_q != 8'h00 && on_q[0] && tmr_q[0] > 8'h01 && !rise[1]
		&& $stable(sel) |=> on_q[0];
	endproperty
	a_pulse_min: assert property (p_pulse_min) else $error("pulse ended early");

	property p_pulse_end;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_PULSE && ontime_q != 8'h00 && tick && tmr_q[0] == 8'h01 && !rise[0]
		&& !rise[1] |=> !on_q[0];
	endproperty
	a_pulse_end: assert property (p_pulse_end) else $error("pulse outlived timer");

	property p_follow;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_PULSE && ontime_q == 8'h00 |=> on_q[1:0] == $past(cmd_q[1:0]);
	endproperty
	a_follow: assert property (p_follow) else $error("output not following command");

	property p_blink_alt;
		@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_USER && pcfg_q[1:0] == AOC_MODE_BLINK ##1 $stable(pcfg_q)
		|-> on_q[1:0] == 2'b01 || on_q[1:0] == 2'b10;
	endproperty
	a_blink_alt: assert property (p_blink_alt) else $error("blink pair not alternating");

	c_pulse: cover property (@(posedge hclk) disable iff (!hresetn) rise[0] ##1 on_q[0]);
	c_latch: cover property (@(posedge hclk) disable iff (!hresetn)
		sel == AOC_SEL_LATCH && on_q[1:0] == 2'b10);
	c_servo: cover property (@(posedge hclk) disable iff (!hresetn) servo_pulse_q[0]);
endmodule : aoc_top

// *** testbench/aoc_station.sv ***
// command station model: an ahb-lite master carrying switching commands
`timescale 1ns/1ps
module aoc_station (
	// clock and reset
	input wire logic hclk,
	input wire logic hresetn,
	// ahb-lite master
	output logic hsel,
	output logic [7:0] haddr,
	output logic [1:0] htrans,
	output logic hwrite,
	output logic [2:0] hsize,
	output logic [31:0] hwdata,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	// waits that ran out
	output int to_cnt
);
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		to_cnt = 0;
	end
	// no fixed latency is assumed; a stuck slave is counted, not waited on forever
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 50);
		if (hready !== 1'b1)
			to_cnt++;
	endtask : wait_rdy
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		wait_rdy();
		rd = hrdata;
	endtask : xfer
endmodule : aoc_station

// *** testbench/tb_top.sv ***
// self-checking bench for the accessory output controller
`timescale 1ns/1ps
module tb_top import aoc_pkg::*;;
	logic hclk;
	logic hresetn;
	logic hsel;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [2:0] hsize;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hreadyout;
	logic hresp;
	logic forced_pulse_mode;
	logic forced_latch_mode;
	logic [7:0] out_q;
	logic [1:0] servo_pulse_q;
	logic [1:0] servo_power_q;
	int to_cnt;
	int err_count;
	int n_tests;
	logic [7:0] cmd_m;
	logic [7:0] lat_m;
	logic [31:0] rd;
	int n_hi;
	int n_full;
	logic w_ok;
	logic [7:0] fixed [6] = '{8'h55, 8'h54, 8'h55, 8'h54, 8'h57, 8'hAA};

	aoc_top uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.forced_pulse_mode(forced_pulse_mode), .forced_latch_mode(forced_latch_mode),
		.out_q(out_q), .servo_pulse_q(servo_pulse_q), .servo_power_q(servo_power_q));
	aoc_station stn (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .to_cnt(to_cnt));

	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		stn.xfer(1'b1, a, d, rd);
		if (to_cnt != 0)
			conclude();
	endtask : wr
	task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
		stn.xfer(1'b0, a, 32'h0, rd);
		if (to_cnt != 0)
			conclude();
		check(what, exp, rd);
	endtask : rdchk
	task automatic conclude();
		err_count += to_cnt;
		$display("mismatches %0d, checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : conclude

	// change-over pair: a new rise on A wins, then B; a repeat changes nothing
	function automatic logic [7:0] latch_next(input logic [7:0] st, input logic [7:0] old,
		input logic [7:0] nw);
		logic [7:0] r;
		logic [7:0] s;
		r = nw & ~old;
		s = st;
		for (int p = 0; p < AOC_NPAIR; p++) begin
			if (r[2*p])
				s[2*p +: 2] = 2'b01;
			else if (r[2*p+1])
				s[2*p +: 2] = 2'b10;
		end
		return s;
	endfunction : latch_next

	// sel bit 0 pulse position, bit 1 latch position; lat says latched drive expected
	task automatic run_mode(input logic [1:0] sel, input logic [1:0] cfg, input logic lat);
		logic [7:0] c;
		logic [1:0] es;
		es = sel[0] ? 2'h1 : sel;
		// drop all commands in the old mode first, so the new mode starts from all off
		wr(AOC_OFF_CMD, 32'h0);
		cmd_m = 8'h00;
		lat_m = 8'h00;
		repeat (3) @(posedge hclk);
		forced_pulse_mode <= sel[0];
		forced_latch_mode <= sel[1];
		wr(AOC_OFF_PAIR_CFG, {24'h0, {4{cfg}}});
		rdchk("select", AOC_OFF_SELECT, {30'h0, es});
		for (int i = 0; i < 18; i++) begin
			c = (i < 6) ? fixed[i] : 8'($urandom);
			wr(AOC_OFF_CMD, {24'h0, c});
			lat_m = latch_next(lat_m, cmd_m, c);
			cmd_m = c;
			repeat (5) @(posedge hclk);
			check("outputs", {24'h0, lat ? lat_m : c}, {24'h0, out_q});
		end
	endtask : run_mode

	initial begin
		err_count = 0;
		n_tests = 0;
		hresetn = 1'b0;
		forced_pulse_mode = 1'b0;
		forced_latch_mode = 1'b0;
		cmd_m = 8'h00;
		lat_m = 8'h00;
		void'($urandom(43928));
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("ontime", AOC_OFF_ONTIME, {24'h0, AOC_ONTIME_RST});
		rdchk("status", AOC_OFF_STATUS, 32'h0080_8000);
		rdchk("unmapped", 8'h1C, 32'h0);
		wr(AOC_OFF_ONTIME, 32'h0);
		run_mode(2'h0, AOC_MODE_LATCH, 1'b1);
		run_mode(2'h0, AOC_MODE_PULSE, 1'b0);
		run_mode(2'h1, AOC_MODE_LATCH, 1'b0);
		run_mode(2'h3, AOC_MODE_LATCH, 1'b0);
		run_mode(2'h2, AOC_MODE_PULSE, 1'b1);
		wr(AOC_OFF_SERVO_CFG, 32'h0000_0002);
		for (int s = 0; s < 3; s++) begin
			forced_pulse_mode <= s[0];
			forced_latch_mode <= s[1];
			repeat (5) @(posedge hclk);
			check("servo power", 32'h2, {30'h0, servo_power_q});
		end
		// two ticks keep the pulse alive far beyond these few cycles
		forced_pulse_mode <= 1'b1;
		forced_latch_mode <= 1'b0;
		wr(AOC_OFF_PAIR_CFG, 32'h55);
		wr(AOC_OFF_CMD, 32'h0);
		wr(AOC_OFF_ONTIME, 32'h2);
		wr(AOC_OFF_CMD, 32'h05);
		repeat (5) @(posedge hclk);
		check("pulse start", 32'h05, {24'h0, out_q});
		wr(AOC_OFF_CMD, 32'h0);
		repeat (5) @(posedge hclk);
		check("pulse held", 32'h05, {24'h0, out_q});
		rdchk("status", AOC_OFF_STATUS, 32'h0080_8005);
		// blinking pairs open on output A; the phase only flips on a 10 ms tick
		forced_pulse_mode <= 1'b0;
		wr(AOC_OFF_PAIR_CFG, 32'hAA);
		repeat (5) @(posedge hclk);
		check("blink", 32'h55, {24'h0, out_q});
		// a freshly lit lamp ramps slowly while one already lit stays near full
		wr(AOC_OFF_PAIR_CFG, 32'h100);
		wr(AOC_OFF_CMD, 32'h02);
		n_hi = 0;
		n_full = 0;
		repeat (4000) begin
			@(posedge hclk);
			n_hi += out_q[1];
			n_full += out_q[2];
		end
		w_ok = n_hi > 0 && n_hi < 1000;
		check("fade ramp", 32'h1, {31'h0, w_ok});
		w_ok = n_full > 3000;
		check("fade full", 32'h1, {31'h0, w_ok});
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		check("reset outputs", 32'h0, {24'h0, out_q});
		hresetn <= 1'b1;
		@(posedge hclk);
		rdchk("ontime", AOC_OFF_ONTIME, {24'h0, AOC_ONTIME_RST});
		// gated servo 0 rests at its target; servo 1 shows its first pulse after reset
		wr(AOC_OFF_SERVO_CFG, 32'h0000_0001);
		@(posedge hclk);
		n_hi = 0;
		n_full = 0;
		for (int n = 0; n < 45000 && (n < 100 || servo_pulse_q[1]); n++) begin
			@(posedge hclk);
			n_hi += servo_pulse_q[1];
			n_full += servo_pulse_q[0];
		end
		check("servo gated", 32'h0, n_full);
		w_ok = n_hi > AOC_PMIN_CYC && n_hi <= 2 * AOC_PMIN_CYC;
		check("servo width", 32'h1, {31'h0, w_ok});
		conclude();
	end
endmodule : tb_top
